/* File: core/mdc_pkg.sv */
// Constants and types for the seven-channel DMA controller
// Function
// - Internal reset follows system reset or a firmware soft reset.
// - Each channel drives its own interrupt output, channels zero to six.
// - Sleep is acknowledged only after all transfers in progress complete.
// - Firmware transfers end at terminal count; hardware ones also on terminate.
// - Exactly one data packet moves per transfer step.
// - Memory addresses only ascend; no top start, no automatic wrap.
// - No chaining: a finished transfer needs new setup and start.
// - A channel runs only with global and channel enables both set.
// - Each channel picks its pacing master from control bits 15 to 9.
// - Device and memory addresses each fixed or advancing by their own bit.
// - Transfer continues below end address; at end, done goes to master if hardware paced.
// - Round robin arbitration; the grant holds until the transfer ends or its hardware master pauses.
// - An active locked channel blocks grants to every unlocked channel.
// - Run bit starts; terminate or done ends; abort bit stops.
// - Direction bit selects master-to-memory or memory-to-master.
// - Interrupt is OR of done, success and error, each enabled.
// - CRC-32 (802.3 polynomial) is computed alongside the data, no delay.
// - CRC may be copied to the destination after the data ends.
// - With CRC on, interrupts wait for the CRC and copy; 32-bit packets.
// - Packet width selectable as one, two or four bytes.
// - Only channel zero holds the CRC generator.
// - Clearing the global enable stops every channel once the packet in flight is written.
package mdc_pkg;
	localparam int         NCH           = 7;
	localparam int         NDEV          = 8;
	localparam int         AW            = 10;
	localparam logic [3:0] BLK_MAIN      = 4'h0;
	localparam logic [3:0] CH_BLK_FIRST  = 4'h1;
	localparam logic [3:0] CH_BLK_LAST   = 4'h7;
	localparam logic [5:0] OFS_MAIN_CTRL = 6'h00;
	localparam logic [5:0] OFS_PACKET    = 6'h04;
	localparam logic [5:0] OFS_ACT       = 6'h00;
	localparam logic [5:0] OFS_MSTART    = 6'h04;
	localparam logic [5:0] OFS_MEND      = 6'h08;
	localparam logic [5:0] OFS_DADDR     = 6'h0C;
	localparam logic [5:0] OFS_CTRL      = 6'h10;
	localparam logic [5:0] OFS_STAT      = 6'h14;
	localparam logic [5:0] OFS_IEN       = 6'h18;
	localparam logic [5:0] OFS_CRC_EN    = 6'h20;
	localparam logic [5:0] OFS_CRC_DATA  = 6'h24;
	localparam logic [5:0] OFS_CRC_POST  = 6'h28;
	localparam int         M_ACT         = 0;
	localparam int         M_SOFT        = 1;
	localparam int         C_DIR         = 0;
	localparam int         C_INC_MEM     = 1;
	localparam int         C_INC_DEV     = 2;
	localparam int         C_LOCK        = 3;
	localparam int         C_DIS_HW      = 4;
	localparam int         C_SIZE_LO     = 5;
	localparam int         C_SIZE_HI     = 6;
	localparam int         C_GO          = 7;
	localparam int         C_ABORT       = 8;
	localparam int         C_DEV_LO      = 9;
	localparam int         C_DEV_HI      = 15;
	localparam int         S_DONE        = 0;
	localparam int         S_OK          = 1;
	localparam int         S_ERR         = 2;
	localparam int         CE_EN         = 0;
	localparam int         CE_POST       = 1;
	localparam logic [1:0] SZ_1          = 2'h0;
	localparam logic [1:0] SZ_2          = 2'h1;
	localparam logic [1:0] SZ_4          = 2'h2;
	localparam logic [2:0] CRC_CH        = 3'h0;
	localparam logic [31:0] CRC_POLY     = 32'hEDB88320;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CHECK = 3'b001,
		ST_RD    = 3'b010,
		ST_WR    = 3'b011,
		ST_FIN   = 3'b100
	} mdc_state_t;
endpackage : mdc_pkg

/* File: core/mdc_dma.sv */
// Seven-channel DMA engine: register file, arbiter, packet mover, CRC-32
`timescale 1ns/1ps
`default_nettype none
module mdc_dma
	import mdc_pkg::*;
(
	input  wire logic            ref_clk_in,      // 40 MHz clock
	input  wire logic            reset_n_in,      // System reset, sync, low
	input  wire logic [AW-1:0]   reg_addr_in,     // Register byte address
	input  wire logic [31:0]     reg_wdata_in,    // Register write data
	input  wire logic            reg_wr_in,       // Register write strobe
	input  wire logic            reg_rd_in,       // Register read strobe
	output logic      [31:0]     reg_rdata_out,   // Read data, next cycle
	output logic      [31:0]     bus_addr_out,    // Data bus address
	output logic      [31:0]     bus_wdata_out,   // Data bus write data
	output logic                 bus_wr_out,      // Data bus write strobe
	output logic                 bus_rd_out,      // Data bus read strobe
	output logic      [1:0]      bus_size_out,    // Packet size code
	input  wire logic [31:0]     bus_rdata_in,    // Read data, cycle after strobe
	input  wire logic [NDEV-1:0] dev_req_in,      // Hardware pacing requests
	input  wire logic [NDEV-1:0] dev_term_in,     // Master terminate
	output logic      [NDEV-1:0] dev_done_out,    // Done pulse to master
	input  wire logic            sleep_req_in,    // From power_clock_reset_unit
	output logic                 sleep_ack_out,   // Safe to sleep
	output logic      [NCH-1:0]  channel_irq_out  // Per-channel interrupt
);
	logic              soft_q;
	logic              dma_rst;
	logic              main_act;
	logic [31:0]       packet;
	logic [NCH-1:0]    ch_act;
	logic [31:0]       mem_addr [NCH];
	logic [31:0]       mem_end  [NCH];
	logic [31:0]       dev_addr [NCH];
	logic [15:0]       ctrl     [NCH];
	logic [2:0]        stat     [NCH];
	logic [2:0]        ien      [NCH];
	logic [1:0]        crc_en;
	logic [31:0]       crc_data;
	logic              crc_post_done;
	mdc_state_t        state;
	logic [2:0]        gnt;
	logic [2:0]        last;
	logic              fin_err;
	logic [NCH-1:0]    act_c;
	logic [NCH-1:0]    cand;
	logic [NCH-1:0]    lock_mask;
	logic [NCH-1:0]    go_c;
	logic              lock_any;
	logic              busy;
	logic [2:0]        pick;
	logic              found;
	logic [3:0]        blk;
	logic [5:0]        ofs;
	logic              ch_sel;
	logic [2:0]        ch_idx;
	logic              wr_main;
	logic              wr_ch;
	logic              wr_crc;
	logic [15:0]       g_ctrl;
	logic [31:0]       g_mem;
	logic [31:0]       g_end;
	logic [31:0]       g_dev;
	logic [31:0]       g_src;
	logic [31:0]       g_dst;
	logic [31:0]       g_step;
	logic [6:0]        g_devn;
	logic              g_devok;
	logic              g_en;
	logic              g_hw;
	logic              g_req;
	logic              g_term;
	logic              g_post;
	logic              crc_upd;
	logic [31:0]       rd_mux;

	function automatic logic [31:0] mdc_crc32(input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		r = c;
		// Reflected form, bit 0 first, as the 802.3 serial order
		for (int i = 0; i < 32; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : mdc_crc32

	function automatic logic [31:0] mdc_step(input logic [1:0] sz);
		case (sz)
			SZ_1:    return 32'h0000_0001;
			SZ_2:    return 32'h0000_0002;
			default: return 32'h0000_0004;
		endcase
	endfunction : mdc_step

	assign blk     = reg_addr_in[9:6];
	assign ofs     = reg_addr_in[5:0];
	assign ch_sel  = (blk >= CH_BLK_FIRST) && (blk <= CH_BLK_LAST);
	assign ch_idx  = 3'(blk - CH_BLK_FIRST);
	assign wr_main = reg_wr_in && (blk == BLK_MAIN) && (ofs == OFS_MAIN_CTRL);
	assign wr_ch   = reg_wr_in && ch_sel;
	assign wr_crc  = wr_ch && (ch_idx == CRC_CH);

	// Soft reset lasts one cycle and clears everything but itself
	assign dma_rst = !reset_n_in || soft_q;

	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in)
			soft_q <= 1'b0;
		else
			soft_q <= wr_main && reg_wdata_in[M_SOFT];
	end

	always_ff @(posedge ref_clk_in) begin
		if (dma_rst)
			main_act <= 1'b0;
		else if (wr_main)
			main_act <= reg_wdata_in[M_ACT];
	end

	// Granted channel view
	assign g_ctrl  = ctrl[gnt];
	assign g_mem   = mem_addr[gnt];
	assign g_end   = mem_end[gnt];
	assign g_dev   = dev_addr[gnt];
	assign g_step  = mdc_step(g_ctrl[C_SIZE_HI:C_SIZE_LO]);
	assign g_devn  = g_ctrl[C_DEV_HI:C_DEV_LO];
	assign g_devok = g_devn < 7'(NDEV);
	assign g_en    = main_act && ch_act[gnt];
	assign g_hw    = !g_ctrl[C_DIS_HW];
	assign g_req   = g_devok && dev_req_in[g_devn[2:0]];
	assign g_term  = g_devok && dev_term_in[g_devn[2:0]];
	assign g_src   = g_ctrl[C_DIR] ? g_mem : g_dev;
	assign g_dst   = g_ctrl[C_DIR] ? g_dev : g_mem;
	assign g_post  = (gnt == CRC_CH) && crc_en[CE_EN] && crc_en[CE_POST];
	assign crc_upd = (state == ST_WR) && (gnt == CRC_CH) && crc_en[CE_EN]
		&& (g_ctrl[C_SIZE_HI:C_SIZE_LO] == SZ_4);

	// Channels wanting service; abort makes a waiting channel eligible to finish
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			act_c[c]     = main_act && ch_act[c] && ctrl[c][C_GO];
			lock_mask[c] = act_c[c] && ctrl[c][C_LOCK];
			go_c[c]      = ctrl[c][C_GO];
			cand[c]      = act_c[c] && (ctrl[c][C_DIS_HW] || ctrl[c][C_ABORT]
				|| (dev_req_in[ctrl[c][C_DEV_LO+:3]] && ctrl[c][C_DEV_HI:C_DEV_LO+3] == 4'h0));
		end
	end

	assign lock_any = |lock_mask;
	// A run bit still set means the transfer is unfinished, even if disabled
	assign busy     = |go_c;

	always_comb begin
		pick  = last;
		found = 1'b0;
		for (int k = 1; k <= NCH; k++) begin
			if (!found && cand[(int'(last) + k) % NCH]
				&& (!lock_any || lock_mask[(int'(last) + k) % NCH])) begin
				pick  = 3'((int'(last) + k) % NCH);
				found = 1'b1;
			end
		end
	end

	// Packet mover: one read then one write per step
	always_ff @(posedge ref_clk_in) begin
		if (dma_rst) begin
			state         <= ST_IDLE;
			gnt           <= 3'h0;
			last          <= 3'(NCH - 1);
			fin_err       <= 1'b0;
			bus_rd_out    <= 1'b0;
			bus_wr_out    <= 1'b0;
			bus_addr_out  <= 32'h0;
			bus_wdata_out <= 32'h0;
			bus_size_out  <= SZ_1;
			dev_done_out  <= '0;
			packet        <= 32'h0;
		end else begin
			bus_rd_out   <= 1'b0;
			bus_wr_out   <= 1'b0;
			dev_done_out <= '0;
			case (state)
				ST_IDLE: begin
					if (found) begin
						gnt   <= pick;
						last  <= pick;
						state <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					if (!g_en) begin
						state <= ST_IDLE;
					end else if (g_ctrl[C_ABORT]) begin
						fin_err <= 1'b1;
						state   <= ST_FIN;
					end else if (g_mem >= g_end || (g_hw && g_term)) begin
						fin_err <= 1'b0;
						state   <= ST_FIN;
						if (g_post) begin
							bus_wr_out    <= 1'b1;
							bus_addr_out  <= g_dst;
							bus_wdata_out <= crc_data;
							bus_size_out  <= SZ_4;
						end
					end else if (g_hw && !g_req) begin
						// Master paused; the locked channel still blocks others
						state <= ST_IDLE;
					end else begin
						bus_rd_out   <= 1'b1;
						bus_addr_out <= g_src;
						bus_size_out <= g_ctrl[C_SIZE_HI:C_SIZE_LO];
						state        <= ST_RD;
					end
				end
				ST_RD: begin
					state <= ST_WR;
				end
				ST_WR: begin
					packet        <= bus_rdata_in;
					bus_wr_out    <= 1'b1;
					bus_addr_out  <= g_dst;
					bus_wdata_out <= bus_rdata_in;
					state         <= ST_CHECK;
				end
				ST_FIN: begin
					if (g_hw && g_devok)
						dev_done_out[g_devn[2:0]] <= 1'b1;
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Channel registers; engine updates are placed last so they win
	always_ff @(posedge ref_clk_in) begin
		if (dma_rst) begin
			ch_act <= '0;
			for (int c = 0; c < NCH; c++) begin
				mem_addr[c] <= 32'h0;
				mem_end[c]  <= 32'h0;
				dev_addr[c] <= 32'h0;
				ctrl[c]     <= 16'h0;
				stat[c]     <= 3'h0;
				ien[c]      <= 3'h0;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (wr_ch && ch_idx == 3'(c)) begin
					case (ofs)
						OFS_ACT:    ch_act[c]   <= reg_wdata_in[0];
						OFS_MSTART: mem_addr[c] <= reg_wdata_in;
						OFS_MEND:   mem_end[c]  <= reg_wdata_in;
						OFS_DADDR:  dev_addr[c] <= reg_wdata_in;
						OFS_CTRL:   ctrl[c]     <= reg_wdata_in[15:0];
						OFS_STAT:   stat[c]     <= stat[c] & ~reg_wdata_in[2:0];
						OFS_IEN:    ien[c]      <= reg_wdata_in[2:0];
						default:    ;
					endcase
				end
				if (state == ST_WR && gnt == 3'(c)) begin
					// Only ever adds; a wrap is the user's setup error
					if (ctrl[c][C_INC_MEM])
						mem_addr[c] <= mem_addr[c] + g_step;
					if (ctrl[c][C_INC_DEV])
						dev_addr[c] <= dev_addr[c] + g_step;
				end
				if (state == ST_FIN && gnt == 3'(c)) begin
					ctrl[c][C_GO]    <= 1'b0;
					ctrl[c][C_ABORT] <= 1'b0;
					// Done lands after any CRC copy, holding the interrupt off
					stat[c][S_DONE]  <= 1'b1;
					if (fin_err)
						stat[c][S_ERR] <= 1'b1;
					else
						stat[c][S_OK]  <= 1'b1;
				end
			end
		end
	end

	// CRC unit, channel zero only; a firmware write beats the update
	always_ff @(posedge ref_clk_in) begin
		if (dma_rst) begin
			crc_en        <= 2'h0;
			crc_data      <= 32'h0;
			crc_post_done <= 1'b0;
		end else begin
			if (wr_crc && ofs == OFS_CRC_EN)
				crc_en <= reg_wdata_in[1:0];
			if (crc_upd)
				crc_data <= mdc_crc32(crc_data, bus_rdata_in);
			if (wr_crc && ofs == OFS_CRC_DATA)
				crc_data <= reg_wdata_in;
			if (wr_crc && ofs == OFS_CRC_POST && reg_wdata_in[0])
				crc_post_done <= 1'b0;
			if (state == ST_FIN && gnt == CRC_CH && g_post && !fin_err)
				crc_post_done <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (dma_rst) begin
			channel_irq_out <= '0;
			sleep_ack_out   <= 1'b0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				channel_irq_out[c] <= |(stat[c] & ien[c]);
			end
			sleep_ack_out <= sleep_req_in && !busy && state == ST_IDLE;
		end
	end

	always_comb begin
		rd_mux = 32'h0;
		if (blk == BLK_MAIN) begin
			if (ofs == OFS_MAIN_CTRL)
				rd_mux = {31'h0, main_act};
			else if (ofs == OFS_PACKET)
				rd_mux = packet;
		end else if (ch_sel) begin
			case (ofs)
				OFS_ACT:      rd_mux = {31'h0, ch_act[ch_idx]};
				OFS_MSTART:   rd_mux = mem_addr[ch_idx];
				OFS_MEND:     rd_mux = mem_end[ch_idx];
				OFS_DADDR:    rd_mux = dev_addr[ch_idx];
				OFS_CTRL:     rd_mux = {16'h0, ctrl[ch_idx]};
				OFS_STAT:     rd_mux = {29'h0, stat[ch_idx]};
				OFS_IEN:      rd_mux = {29'h0, ien[ch_idx]};
				OFS_CRC_EN:   rd_mux = (ch_idx == CRC_CH) ? {30'h0, crc_en} : 32'h0;
				OFS_CRC_DATA: rd_mux = (ch_idx == CRC_CH) ? crc_data : 32'h0;
				OFS_CRC_POST: rd_mux = (ch_idx == CRC_CH) ? {31'h0, crc_post_done} : 32'h0;
				default:      rd_mux = 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (dma_rst)
			reg_rdata_out <= 32'h0;
		else
			reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0;
	end

	// Checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (dma_rst);

	logic [6:0] g_lock_hit;
	assign g_lock_hit = {6'h0, lock_mask[gnt]};

	property p_soft;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		wr_main && reg_wdata_in[M_SOFT] |=> dma_rst ##1 !dma_rst;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset not one cycle");

	property p_irq0;
		(stat[0][S_DONE] && ien[0][S_DONE]) |=> channel_irq_out[0];
	endproperty
	a_irq0: assert property (p_irq0) else $error("channel 0 irq missing");

	property p_sleep;
		sleep_ack_out |-> state == ST_IDLE && $past(sleep_req_in);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep acked while moving");

	sequence s_rd;
		bus_rd_out ##1 (!bus_rd_out && state == ST_WR);
	endsequence
	property p_pkt;
		bus_rd_out |-> s_rd ##1 (bus_wr_out && !bus_rd_out);
	endproperty
	a_pkt: assert property (p_pkt) else $error("packet not read then written");

	property p_asc;
		(state == ST_WR && !wr_ch) |=> g_mem >= $past(g_mem);
	endproperty
	a_asc: assert property (p_asc) else $error("memory address went down");

	property p_en;
		bus_rd_out |-> $past(g_en);
	endproperty
	a_en: assert property (p_en) else $error("disabled channel moved data");

	property p_lock;
		(state == ST_IDLE && found && lock_any) |=> g_lock_hit == 7'h1;
	endproperty
	a_lock: assert property (p_lock) else $error("grant passed a lock");

	property p_end;
		(state == ST_CHECK && g_en && !g_ctrl[C_ABORT] && g_mem == g_end)
			|=> state == ST_FIN ##1 state == ST_IDLE;
	endproperty
	a_end: assert property (p_end) else $error("end address not honoured");

	property p_nochain;
		state == ST_FIN |=> !g_ctrl[C_GO] && stat[gnt][S_DONE];
	endproperty
	a_nochain: assert property (p_nochain) else $error("run bit survived end");

	property p_crc;
		(crc_upd && !wr_crc) |=> crc_data == mdc_crc32($past(crc_data), $past(bus_rdata_in));
	endproperty
	a_crc: assert property (p_crc) else $error("crc step wrong");
endmodule : mdc_dma
`default_nettype wire

/* File: sim/mdc_mem_model.sv */
// Word memory on the engine's data bus, answering reads one cycle later
`timescale 1ns/1ps
`default_nettype none
module mdc_mem_model (
	input  wire logic        clk_in,    // Bus clock
	input  wire logic [31:0] addr_in,   // Byte address
	input  wire logic [31:0] wdata_in,  // Write data
	input  wire logic        wr_in,     // Write strobe
	input  wire logic        rd_in,     // Read strobe
	output logic      [31:0] rdata_out  // Valid only the cycle after rd_in
);
	logic [31:0] mem [0:255];
	logic [31:0] last;

	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 32'h5A5A0000 + 32'(i);
		end
		last = 32'h0;
		rdata_out = 32'h0;
	end

	// Whole words only: every transfer that moves data in this bench uses four-byte packets
	always @(posedge clk_in) begin
		if (wr_in) begin
			mem[addr_in[9:2]] <= wdata_in;
		end
		if (rd_in) begin
			rdata_out <= mem[addr_in[9:2]];
			last <= mem[addr_in[9:2]];
		end else begin
			rdata_out <= ~last; // Stale data must never pass for a fresh read
		end
	end
endmodule : mdc_mem_model
`default_nettype wire

/* File: sim/mdc_dma_tb_top.sv */
// Self-checking bench for the seven-channel DMA engine
`timescale 1ns/1ps
`default_nettype none
module mdc_dma_tb_top;
	import mdc_pkg::*;
	logic              clk;
	logic              rst_n;
	logic [AW-1:0]     reg_addr;
	logic [31:0]       reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [31:0]       reg_rdata;
	logic [31:0]       bus_addr;
	logic [31:0]       bus_wdata;
	logic              bus_wr;
	logic              bus_rd;
	logic [31:0]       bus_rdata;
	logic [NDEV-1:0]   dev_req;
	logic [NDEV-1:0]   dev_done;
	logic [NDEV-1:0]   dev_term;
	logic [1:0]        bus_size;
	logic              sleep_req;
	logic              sleep_ack;
	logic [NCH-1:0]    irq;
	logic [15:0]       watch;
	logic [31:0]       rv;
	int                fail_count = 0;
	int                checks_done = 0;
	int                rd_count = 0;
	int                n0;

	assign watch = {dev_done, 1'b0, irq};

	mdc_dma mdc_dma_i (
		.ref_clk_in      (clk),
		.reset_n_in      (rst_n),
		.reg_addr_in     (reg_addr),
		.reg_wdata_in    (reg_wdata),
		.reg_wr_in       (reg_wr),
		.reg_rd_in       (reg_rd),
		.reg_rdata_out   (reg_rdata),
		.bus_addr_out    (bus_addr),
		.bus_wdata_out   (bus_wdata),
		.bus_wr_out      (bus_wr),
		.bus_rd_out      (bus_rd),
		.bus_size_out    (bus_size),
		.bus_rdata_in    (bus_rdata),
		.dev_req_in      (dev_req),
		.dev_term_in     (dev_term),
		.dev_done_out    (dev_done),
		.sleep_req_in    (sleep_req),
		.sleep_ack_out   (sleep_ack),
		.channel_irq_out (irq)
	);

	mdc_mem_model mdc_mem_model_i (
		.clk_in    (clk),
		.addr_in   (bus_addr),
		.wdata_in  (bus_wdata),
		.wr_in     (bus_wr),
		.rd_in     (bus_rd),
		.rdata_out (bus_rdata)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (bus_rd) begin
			rd_count <= rd_count + 1;
		end
	end

	function automatic logic [AW-1:0] ra(input int n, input logic [5:0] ofs);
		return {CH_BLK_FIRST + 4'(n), ofs};
	endfunction : ra

	function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		r = c ^ d;
		for (int i = 0; i < 32; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_word

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	// Bounded wait; a timeout shows up as a failed compare and ends the run
	task automatic wait_bit(input int b);
		int n;
		n = 0;
		while (watch[b] !== 1'b1 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmp({31'h0, watch[b]}, 32'h1);
		if (n >= 300) end_of_test();
	endtask : wait_bit

	task automatic setup(input int n, input logic [31:0] ms, me, da);
		wr(ra(n, OFS_ACT), 32'h1);
		wr(ra(n, OFS_MSTART), ms);
		wr(ra(n, OFS_MEND), me);
		wr(ra(n, OFS_DADDR), da);
		wr(ra(n, OFS_IEN), 32'h7);
	endtask : setup

	initial begin
		rst_n = 1'b0;
		reg_addr = '0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		dev_req = 8'h00;
		dev_term = 8'h00;
		sleep_req = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(ra(0, OFS_CTRL), rv); cmp(rv, 32'h0);
		rd({BLK_MAIN, OFS_MAIN_CTRL}, rv); cmp(rv, 32'h0);
		wr(ra(1, OFS_CRC_DATA), 32'hFFFFFFFF);
		rd(ra(1, OFS_CRC_DATA), rv); cmp(rv, 32'h0);
		rd(10'h3FC, rv); cmp(rv, 32'h0);
		// Two-word copy on channel 0, firmware paced
		wr({BLK_MAIN, OFS_MAIN_CTRL}, 32'h1);
		setup(0, 32'h100, 32'h108, 32'h200);
		wr(ra(0, OFS_CTRL), 32'hD7);
		wait_bit(0);
		cmp(mdc_mem_model_i.mem[8'h80], 32'h5A5A0040);
		cmp(mdc_mem_model_i.mem[8'h81], 32'h5A5A0041);
		cmp(32'(rd_count), 32'h2);
		rd(ra(0, OFS_MSTART), rv); cmp(rv, 32'h108);
		rd(ra(0, OFS_DADDR), rv); cmp(rv, 32'h208);
		rd(ra(0, OFS_STAT), rv); cmp(rv, 32'h3);
		rd(ra(0, OFS_CTRL), rv); cmp(rv, 32'h57);
		rd({BLK_MAIN, OFS_PACKET}, rv); cmp(rv, 32'h5A5A0041);
		cmp(32'(rd_count), 32'h2);
		wr(ra(0, OFS_IEN), 32'h0);
		repeat (2) @(posedge clk);
		#1;
		cmp({25'h0, irq}, 32'h0);
		// CRC over one word, copied after the data
		wr(ra(0, OFS_STAT), 32'h7);
		wr(ra(0, OFS_CRC_EN), 32'h3);
		wr(ra(0, OFS_CRC_DATA), 32'hFFFFFFFF);
		setup(0, 32'h110, 32'h114, 32'h300);
		wr(ra(0, OFS_CTRL), 32'hD7);
		wait_bit(0);
		cmp(mdc_mem_model_i.mem[8'hC0], 32'h5A5A0044);
		cmp(mdc_mem_model_i.mem[8'hC1], crc_word(32'hFFFFFFFF, 32'h5A5A0044));
		rd(ra(0, OFS_CRC_DATA), rv); cmp(rv, crc_word(32'hFFFFFFFF, 32'h5A5A0044));
		rd(ra(0, OFS_CRC_POST), rv); cmp(rv, 32'h1);
		// Global enable off holds a ready channel and blocks sleep
		wr({BLK_MAIN, OFS_MAIN_CTRL}, 32'h0);
		setup(1, 32'h120, 32'h124, 32'h140);
		wr(ra(1, OFS_CTRL), 32'hD7);
		@(posedge clk);
		sleep_req <= 1'b1;
		n0 = rd_count;
		repeat (20) @(posedge clk);
		#1;
		cmp(32'(rd_count), 32'(n0));
		cmp({31'h0, sleep_ack}, 32'h0);
		wr({BLK_MAIN, OFS_MAIN_CTRL}, 32'h1);
		wait_bit(1);
		cmp(mdc_mem_model_i.mem[8'h50], 32'h5A5A0048);
		repeat (3) @(posedge clk);
		#1;
		cmp({31'h0, sleep_ack}, 32'h1);
		@(posedge clk);
		sleep_req <= 1'b0;
		// Hardware paced, device to memory, fixed device address
		setup(2, 32'h180, 32'h188, 32'h1C0);
		wr(ra(2, OFS_CTRL), 32'h6C2);
		n0 = rd_count;
		repeat (10) @(posedge clk);
		#1;
		cmp(32'(rd_count), 32'(n0));
		@(posedge clk);
		dev_req <= 8'h08;
		wait_bit(11);
		@(posedge clk);
		dev_req <= 8'h00;
		cmp(mdc_mem_model_i.mem[8'h60], 32'h5A5A0070);
		cmp(mdc_mem_model_i.mem[8'h61], 32'h5A5A0070);
		cmp({30'h0, bus_size}, {30'h0, SZ_4});
		// Abort ends a channel with the error flag
		setup(3, 32'h1A0, 32'h1A4, 32'h1E0);
		wr(ra(3, OFS_CTRL), 32'h190);
		wait_bit(3);
		rd(ra(3, OFS_STAT), rv); cmp(rv & 32'h4, 32'h4);
		// Locked hardware channel on its own device, ended by terminate
		setup(4, 32'h1C0, 32'h1C8, 32'h1E8);
		wr(ra(4, OFS_CTRL), 32'hACA);
		n0 = rd_count;
		@(posedge clk);
		dev_req  <= 8'h20;
		dev_term <= 8'h20;
		wait_bit(13);
		@(posedge clk);
		dev_req  <= 8'h00;
		dev_term <= 8'h00;
		cmp(32'(rd_count), 32'(n0));
		rd(ra(4, OFS_STAT), rv); cmp(rv, 32'h3);
		// Soft reset clears the whole module
		wr({BLK_MAIN, OFS_MAIN_CTRL}, 32'h3);
		rd({BLK_MAIN, OFS_MAIN_CTRL}, rv); cmp(rv, 32'h0);
		rd(ra(0, OFS_CTRL), rv); cmp(rv, 32'h0);
		cmp({25'h0, irq}, 32'h0);
		end_of_test();
	end
endmodule : mdc_dma_tb_top
`default_nettype wire
